// >>> hw/core_defs.svh
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define A_OPERAND 8'h00
`define A_SECOND 8'h01
`define A_STATUS 8'h02
`define A_STACK 8'h03
`define A_DPTR0_LO 8'h04
`define A_DPTR0_HI 8'h05
`define A_DPTR1_LO 8'h06
`define A_DPTR1_HI 8'h07
`define A_DPTR_SEL 8'h08
`define A_CLK_CTRL 8'h09
`define A_PORT_BASE 8'h10
`define A_TMR_BASE 8'h20
`define A_TMR_CTRL 8'h28
`define A_WD_CTRL 8'h30
`define A_SCR_ADDR 8'h40
`define A_SCR_DATA 8'h41
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSW_CY 7
`define PSW_AC 6
`define PSW_F0 5
`define PSW_RS_HI 4
`define PSW_RS_LO 3
`define PSW_OV 2
`define PSW_F1 1
`define PSW_P 0
`define CLK_SB_BIT 2
`define TMR_OVF_LO 4
`define WD_EN_BIT 0
`define WD_SEL_LO 1
`define WD_SEL_HI 2
`define WD_RESTART_BIT 3
`define WD_FLAG_BIT 4
// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define RST_STACK 8'h07
`define RST_PORT 8'hff
`define DIV_CLK4 4
`define DIV_CLK64 64
`define DIV_CLK1024 1024
`endif

// >>> hw/core_pkg.sv
// ----------------------------------------------------------------
// Shared types of the core
// ----------------------------------------------------------------
package core_pkg;
  // Machine cycle length select, code 2'b11 is illegal
  typedef enum logic [1:0] {
    MODE_DIV4 = 2'b00,
    MODE_DIV64 = 2'b01,
    MODE_DIV1024 = 2'b10
  } clk_mode_t;
  // Operations chosen by instruction decode
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_ADDC = 3'b001,
    ALU_SUBB = 3'b010,
    ALU_AND = 3'b011,
    ALU_OR = 3'b100,
    ALU_XOR = 3'b101,
    ALU_MUL = 3'b110,
    ALU_DIV = 3'b111
  } alu_op_t;
  // Result of one arithmetic step
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic cy;
    logic ac;
    logic ov;
  } alu_res_t;
endpackage : core_pkg

// >>> hw/scratch_mem.sv
`timescale 1ns/10ps
`default_nettype none
// Scratchpad store with registered read data
module scratch_mem #(
  parameter int W = 8,
  parameter int DEPTH = 256
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  // Storage array, no reset
  logic [W-1:0] mem [DEPTH];
  // Write side
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  // Read side, data one cycle after the address
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : scratch_mem
`default_nettype wire

// >>> hw/core_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_defs.svh"
// Overview of operation
// - Default machine cycle lasts four clocks
// - Cycle length selectable as 4, 64, 1024
// - Switchback returns to four clocks on events
// - Arithmetic uses both operand registers, decode driven
// - Arithmetic results update status word flags
// - Status word holds carry, aux, user, bank, overflow, parity
// - Second operand feeds every step; takes product high, remainder
// - Two data pointers, one select bit
// - Stack pointer names last pushed location
// - Four ports; bus on ports zero, two
// - Port writes latch, port reads see pins
// - Three readable, writable sixteen bit timers
// - 256 byte scratchpad for data and stack
// - Watchdog resets CPU when not cleared
module core_regs
  import core_pkg::*;
#(
  parameter bit ROMLESS = 1'b1,
  parameter int WD_EXP = 17
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Instruction decode
  input wire logic alu_go_i,
  input wire alu_op_t alu_op_i,
  output logic alu_done_o,
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  input wire logic pop_i,
  // External data access
  input wire logic ext_access_i,
  input wire logic dptr_inc_i,
  output logic [15:0] ext_addr_o,
  // Wake events
  input wire logic irq_i,
  input wire logic serial_act_i,
  // Port pins
  input wire logic [3:0][7:0] port_pin_i,
  output logic [3:0][7:0] port_out_o,
  output logic [3:0][7:0] port_oe_o,
  // Cycle and reset outputs
  output logic cycle_o,
  output logic cpu_reset_o
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Clocks per machine cycle for a mode
  function automatic logic [10:0] cyc_len(input clk_mode_t m);
    logic [10:0] n;
    n = 11'(`DIV_CLK1024);
    unique case (m)
      MODE_DIV4: n = 11'(`DIV_CLK4);
      MODE_DIV64: n = 11'(`DIV_CLK64);
      MODE_DIV1024: n = 11'(`DIV_CLK1024);
      default: n = 11'(`DIV_CLK1024);
    endcase
    return n;
  endfunction : cyc_len
  // Last watchdog count of an interval
  function automatic logic [31:0] wd_limit(input logic [1:0] sel);
    return (32'h0000_0001 << (WD_EXP + 2 * int'(sel))) - 32'h0000_0001;
  endfunction : wd_limit
  // One arithmetic step
  function automatic alu_res_t alu_calc(input alu_op_t op,
      input logic [7:0] a, input logic [7:0] b,
      input logic ci, input logic ai, input logic oi);
    alu_res_t r;
    logic [8:0] s;
    logic [4:0] h;
    logic [15:0] p;
    logic c;
    r = '{a: a, b: b, cy: ci, ac: ai, ov: oi};
    c = (op == ALU_ADD) ? 1'b0 : ci;
    s = '0;
    h = '0;
    p = {8'h00, a} * {8'h00, b};
    unique case (op)
      ALU_ADD, ALU_ADDC: begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, c};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        r.a = s[7:0];
        r.cy = s[8];
        r.ac = h[4];
        r.ov = (a[7] == b[7]) && (s[7] != a[7]);
      end
      ALU_SUBB: begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        r.a = s[7:0];
        r.cy = s[8];
        r.ac = h[4];
        r.ov = (a[7] != b[7]) && (s[7] != a[7]);
      end
      ALU_AND: r.a = a & b;
      ALU_OR: r.a = a | b;
      ALU_XOR: r.a = a ^ b;
      ALU_MUL: begin
        r.a = p[7:0];
        r.b = p[15:8];
        r.cy = 1'b0;
        r.ov = |p[15:8];
      end
      ALU_DIV: begin
        r.cy = 1'b0;
        r.ov = (b == 8'h00);
        if (b != 8'h00) begin
          r.a = a / b;
          r.b = a % b;
        end
      end
    endcase
    return r;
  endfunction : alu_calc
  // ----------------------------------------------------------------
  // Machine cycle divider
  // ----------------------------------------------------------------
  logic [9:0] cnt_reg, cnt_next; // Clock count within a cycle
  logic cycle_reg, cycle_next; // One clock pulse per machine cycle
  clk_mode_t clk_mode_reg, clk_mode_next; // Selected cycle length
  logic [10:0] cyc_last; // Last count of the current length
  // Next divider count
  always_comb begin
    cyc_last = cyc_len(clk_mode_reg) - 11'h001;
    if ({1'b0, cnt_reg} >= cyc_last) begin
      cnt_next = 10'h000;
      cycle_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 10'h001;
      cycle_next = 1'b0;
    end
  end
  // Divider registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 10'h000;
      cycle_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cycle_reg <= cycle_next;
    end
  end
  assign cycle_o = cycle_reg;
  // ----------------------------------------------------------------
  // Register set
  // ----------------------------------------------------------------
  logic [7:0] operand_reg, operand_next; // Primary operand
  logic [7:0] second_reg, second_next; // Second operand
  logic [7:0] psw_reg, psw_next; // Program status word
  logic [7:0] sp_reg, sp_next; // Stack pointer
  logic [1:0][15:0] dptr_reg, dptr_next; // Data pointers
  logic dsel_reg, dsel_next; // Active pointer select
  logic sb_en_reg, sb_en_next; // Switchback enable
  logic [3:0][7:0] latch_reg, latch_next; // Port output latches
  logic [2:0][15:0] tmr_reg, tmr_next; // Timer counts
  logic [2:0] run_reg, run_next; // Timer run bits
  logic [2:0] ovf_reg, ovf_next; // Timer overflow flags
  logic [2:0] wd_ctl_reg, wd_ctl_next; // Enable and interval
  logic wd_flag_reg, wd_flag_next; // Watchdog timeout flag
  logic [31:0] wd_cnt_reg, wd_cnt_next; // Watchdog count
  logic [7:0] scr_addr_reg, scr_addr_next; // Scratchpad window
  logic [7:0] rdata_next, scr_q;
  logic [15:0] ext_addr_next;
  logic [3:0][7:0] pout_next, poe_next;
  logic alu_take, wd_fire, mem_we;
  logic [7:0] mem_waddr, mem_wdata;
  alu_res_t res;
  // Next values of every register
  always_comb begin
    operand_next = operand_reg;
    second_next = second_reg;
    psw_next = psw_reg;
    sp_next = sp_reg;
    dptr_next = dptr_reg;
    dsel_next = dsel_reg;
    clk_mode_next = clk_mode_reg;
    sb_en_next = sb_en_reg;
    latch_next = latch_reg;
    tmr_next = tmr_reg;
    run_next = run_reg;
    ovf_next = ovf_reg;
    wd_ctl_next = wd_ctl_reg;
    wd_flag_next = wd_flag_reg;
    wd_cnt_next = wd_cnt_reg;
    scr_addr_next = scr_addr_reg;
    mem_we = 1'b0;
    mem_waddr = scr_addr_reg;
    mem_wdata = reg_wdata_i;
    rdata_next = 8'h00;
    alu_take = alu_go_i && cycle_reg;
    res = alu_calc(alu_op_i, operand_reg, second_reg, psw_reg[`PSW_CY],
      psw_reg[`PSW_AC], psw_reg[`PSW_OV]);
    // Software writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `A_OPERAND: operand_next = reg_wdata_i;
        `A_SECOND: second_next = reg_wdata_i;
        // Flag layout, parity stays hardware owned
        `A_STATUS: psw_next[7:1] = reg_wdata_i[7:1];
        `A_STACK: sp_next = reg_wdata_i;
        `A_DPTR0_LO: dptr_next[0][7:0] = reg_wdata_i;
        `A_DPTR0_HI: dptr_next[0][15:8] = reg_wdata_i;
        `A_DPTR1_LO: dptr_next[1][7:0] = reg_wdata_i;
        `A_DPTR1_HI: dptr_next[1][15:8] = reg_wdata_i;
        `A_DPTR_SEL: dsel_next = reg_wdata_i[0];
        `A_CLK_CTRL: begin
          if (reg_wdata_i[1:0] != 2'b11) begin
            clk_mode_next = clk_mode_t'(reg_wdata_i[1:0]);
          end
          sb_en_next = reg_wdata_i[`CLK_SB_BIT];
        end
        `A_TMR_CTRL: begin
          run_next = reg_wdata_i[2:0];
          ovf_next = ovf_reg & reg_wdata_i[`TMR_OVF_LO+:3];
        end
        `A_WD_CTRL: begin
          wd_ctl_next = reg_wdata_i[`WD_SEL_HI:`WD_EN_BIT];
          if (reg_wdata_i[`WD_RESTART_BIT]) begin
            wd_cnt_next = 32'h0000_0000;
          end
          if (reg_wdata_i[`WD_FLAG_BIT]) begin
            wd_flag_next = 1'b0;
          end
        end
        `A_SCR_ADDR: scr_addr_next = reg_wdata_i;
        `A_SCR_DATA: mem_we = 1'b1;
        default: ;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (reg_addr_i == 8'(`A_PORT_BASE + i)) begin
          latch_next[i] = reg_wdata_i;
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (reg_addr_i == 8'(`A_TMR_BASE + 2 * i)) begin
          tmr_next[i][7:0] = reg_wdata_i;
        end
        if (reg_addr_i == 8'(`A_TMR_BASE + 2 * i + 1)) begin
          tmr_next[i][15:8] = reg_wdata_i;
        end
      end
    end
    if (clk_mode_reg != MODE_DIV4 && sb_en_reg && (irq_i || serial_act_i))
      begin
      clk_mode_next = MODE_DIV4;
    end
    // Arithmetic step on a machine cycle
    if (alu_take) begin
      operand_next = res.a;
      second_next = res.b;
      psw_next[`PSW_CY] = res.cy;
      psw_next[`PSW_AC] = res.ac;
      psw_next[`PSW_OV] = res.ov;
    end
    if (dptr_inc_i) begin
      dptr_next[dsel_reg] = dptr_reg[dsel_reg] + 16'h0001;
    end
    if (push_i) begin
      sp_next = sp_reg + 8'h01;
      mem_we = 1'b1;
      mem_waddr = sp_reg + 8'h01;
      mem_wdata = push_data_i;
    end else if (pop_i) begin
      sp_next = sp_reg - 8'h01;
    end
    // Timers count machine cycles, overflow set wins
    for (int i = 0; i < 3; i++) begin
      if (run_reg[i] && cycle_reg) begin
        tmr_next[i] = tmr_reg[i] + 16'h0001;
        if (tmr_reg[i] == 16'hffff) begin
          ovf_next[i] = 1'b1;
        end
      end
    end
    wd_fire = wd_ctl_reg[`WD_EN_BIT] && cycle_reg &&
      (wd_cnt_reg >= wd_limit(wd_ctl_reg[`WD_SEL_HI:`WD_SEL_LO]));
    if (wd_fire) begin
      wd_cnt_next = 32'h0000_0000;
      wd_flag_next = 1'b1;
    end else if (wd_ctl_reg[`WD_EN_BIT] && cycle_reg) begin
      wd_cnt_next = wd_cnt_reg + 32'h0000_0001;
    end
    psw_next[`PSW_P] = ^operand_next;
    // Read data, zero for unmapped addresses
    if (reg_rd_i) begin
      case (reg_addr_i)
        `A_OPERAND: rdata_next = operand_reg;
        `A_SECOND: rdata_next = second_reg;
        `A_STATUS: rdata_next = psw_reg;
        `A_STACK: rdata_next = sp_reg;
        `A_DPTR0_LO: rdata_next = dptr_reg[0][7:0];
        `A_DPTR0_HI: rdata_next = dptr_reg[0][15:8];
        `A_DPTR1_LO: rdata_next = dptr_reg[1][7:0];
        `A_DPTR1_HI: rdata_next = dptr_reg[1][15:8];
        `A_DPTR_SEL: rdata_next = {7'h00, dsel_reg};
        `A_CLK_CTRL: rdata_next = {5'h00, sb_en_reg, clk_mode_reg};
        `A_TMR_CTRL: rdata_next = {1'b0, ovf_reg, 1'b0, run_reg};
        `A_WD_CTRL: rdata_next = {3'h0, wd_flag_reg, 1'b0, wd_ctl_reg};
        `A_SCR_ADDR: rdata_next = scr_addr_reg;
        `A_SCR_DATA: rdata_next = scr_q;
        default: rdata_next = 8'h00;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (reg_addr_i == 8'(`A_PORT_BASE + i)) begin
          rdata_next = port_pin_i[i];
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (reg_addr_i == 8'(`A_TMR_BASE + 2 * i)) begin
          rdata_next = tmr_reg[i][7:0];
        end
        if (reg_addr_i == 8'(`A_TMR_BASE + 2 * i + 1)) begin
          rdata_next = tmr_reg[i][15:8];
        end
      end
    end
    // Selected pointer drives the external address
    ext_addr_next = dptr_reg[dsel_reg];
    // Ports drive low for a zero latch bit, bus overrides
    for (int i = 0; i < 4; i++) begin
      pout_next[i] = latch_reg[i];
      poe_next[i] = ~latch_reg[i];
    end
    if (ROMLESS && ext_access_i) begin
      pout_next[0] = dptr_reg[dsel_reg][7:0];
      pout_next[2] = dptr_reg[dsel_reg][15:8];
      poe_next[0] = 8'hff;
      poe_next[2] = 8'hff;
    end
  end
  // Register stage
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      operand_reg <= 8'h00;
      second_reg <= 8'h00;
      psw_reg <= 8'h00;
      sp_reg <= `RST_STACK;
      dptr_reg <= '0;
      dsel_reg <= 1'b0;
      clk_mode_reg <= MODE_DIV4;
      sb_en_reg <= 1'b0;
      latch_reg <= {4{`RST_PORT}};
      tmr_reg <= '0;
      run_reg <= 3'h0;
      ovf_reg <= 3'h0;
      wd_ctl_reg <= 3'h0;
      wd_flag_reg <= 1'b0;
      wd_cnt_reg <= 32'h0000_0000;
      scr_addr_reg <= 8'h00;
      reg_rdata_o <= 8'h00;
      alu_done_o <= 1'b0;
      cpu_reset_o <= 1'b0;
      ext_addr_o <= 16'h0000;
      port_out_o <= {4{`RST_PORT}};
      port_oe_o <= '0;
    end else begin
      operand_reg <= operand_next;
      second_reg <= second_next;
      psw_reg <= psw_next;
      sp_reg <= sp_next;
      dptr_reg <= dptr_next;
      dsel_reg <= dsel_next;
      clk_mode_reg <= clk_mode_next;
      sb_en_reg <= sb_en_next;
      latch_reg <= latch_next;
      tmr_reg <= tmr_next;
      run_reg <= run_next;
      ovf_reg <= ovf_next;
      wd_ctl_reg <= wd_ctl_next;
      wd_flag_reg <= wd_flag_next;
      wd_cnt_reg <= wd_cnt_next;
      scr_addr_reg <= scr_addr_next;
      reg_rdata_o <= rdata_next;
      alu_done_o <= alu_take;
      cpu_reset_o <= wd_fire;
      ext_addr_o <= ext_addr_next;
      port_out_o <= pout_next;
      port_oe_o <= poe_next;
    end
  end
  // Scratchpad store, read through the window address
  scratch_mem #(.W(8), .DEPTH(256)) u_scratch (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(scr_addr_reg),
    .rdata_o(scr_q)
  );
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [10:0] gap_reg; // Clocks since the last cycle pulse
  logic stable_reg; // Mode unchanged since the last pulse
  // Helper tracking for cycle length checks
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_reg <= 11'h000;
      stable_reg <= 1'b0;
    end else begin
      gap_reg <= cycle_reg ? 11'h000 : gap_reg + 11'h001;
      stable_reg <= (clk_mode_next == clk_mode_reg) && (cycle_reg || stable_reg);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_cycle_four: assert property ((cycle_reg && clk_mode_reg == MODE_DIV4)
    ##1 (clk_mode_reg == MODE_DIV4 && !cycle_reg)[*3] |=> cycle_reg)
    else $error("four clock cycle broken");
  a_cycle_length: assert property (cycle_reg && stable_reg |->
    gap_reg == cyc_len(clk_mode_reg) - 11'h001)
    else $error("cycle length wrong for mode");
  a_switch_back: assert property (clk_mode_reg != MODE_DIV4 && sb_en_reg &&
    (irq_i || serial_act_i) |=> clk_mode_reg == MODE_DIV4)
    else $error("switchback missed");
  a_alu_add: assert property (alu_take && alu_op_i == ALU_ADD |=>
    operand_reg == 8'($past(operand_reg) + $past(second_reg)) &&
    alu_done_o)
    else $error("add result wrong");
  a_add_carry: assert property (alu_take && alu_op_i == ALU_ADD |=>
    psw_reg[`PSW_CY] == ({1'b0, $past(operand_reg)} +
    {1'b0, $past(second_reg)} > 9'h0ff))
    else $error("carry flag wrong");
  a_mul_split: assert property (alu_take && alu_op_i == ALU_MUL |=>
    {second_reg, operand_reg} ==
    {8'h00, $past(operand_reg)} * {8'h00, $past(second_reg)})
    else $error("product split wrong");
  a_dptr_sel: assert property (##1 ext_addr_o ==
    $past(dptr_reg[dsel_reg]))
    else $error("wrong pointer selected");
  a_push_sp: assert property (push_i |=>
    sp_reg == 8'($past(sp_reg) + 8'h01))
    else $error("push did not advance stack");
  a_port_pins: assert property (reg_rd_i &&
    reg_addr_i == `A_PORT_BASE |=> reg_rdata_o == $past(port_pin_i[0]))
    else $error("port read not from pins");
  a_timer_count: assert property (cycle_reg && run_reg[0] && !reg_wr_i |=>
    tmr_reg[0] == 16'($past(tmr_reg[0]) + 16'h0001))
    else $error("timer did not count");
  a_wd_reset: assert property (wd_fire |=> cpu_reset_o && wd_flag_reg &&
    wd_cnt_reg == 32'h0000_0000)
    else $error("watchdog reset missing");
  a_parity_flag: assert property (psw_reg[`PSW_P] == ^operand_reg)
    else $error("parity flag stale");
  c_switch_back: cover property (clk_mode_reg == MODE_DIV1024 ##1
    clk_mode_reg == MODE_DIV4);
  c_alu_div: cover property (alu_take && alu_op_i == ALU_DIV);
  c_wd_fire: cover property (cpu_reset_o);
  c_tmr_wrap: cover property (ovf_reg[0]);
endmodule : core_regs
`default_nettype wire

// >>> dv/ext_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far side of the ports: pulled-up pins and outside low drive
module ext_mem_model (
  // Port drive from the core
  input wire logic [3:0][7:0] port_out_i,
  input wire logic [3:0][7:0] port_oe_i,
  // Low levels forced by outside parts on ports 1 and 3
  input wire logic [7:0] drive_i,
  // Resolved pin levels
  output logic [3:0][7:0] pin_o
);
  // pins show drive, pull-up or outside low
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_o[p] = (port_out_i[p] | ~port_oe_i[p]) & (p % 2 ? drive_i : 8'hff);
    end
  end
endmodule : ext_mem_model
`default_nettype wire

// >>> dv/accumulator_core_register_set_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Bench for the core register set
module accumulator_core_register_set_tb_top;
  import core_pkg::*;
  logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, go = 0, push = 0, pop = 0;
  logic ext = 0, dinc = 0, irq = 0, ser = 0, done, cyc, cpur;
  logic [7:0] addr = 0, wd = 0, rdata, pd = 0, drv = 8'hff, sd = 8'h32;
  logic [7:0] ea, eb, ep;
  logic cy, ac, ov;
  logic [15:0] xa;
  logic [3:0][7:0] pin, pout, poe;
  alu_op_t op = ALU_ADD;
  int error_cnt = 0, n_checks = 0, n, a, b, s, k, ci;
  // Clock of 4 ns
  always #2 clk = ~clk;
  core_regs #(.WD_EXP(2)) dut_u (.sys_clk_i(clk), .rst_i(rst),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .alu_go_i(go), .alu_op_i(op), .alu_done_o(done),
    .push_i(push), .push_data_i(pd), .pop_i(pop), .ext_access_i(ext),
    .dptr_inc_i(dinc), .ext_addr_o(xa), .irq_i(irq), .serial_act_i(ser),
    .port_pin_i(pin), .port_out_o(pout), .port_oe_o(poe), .cycle_o(cyc),
    .cpu_reset_o(cpur));
  ext_mem_model mem_u (.port_out_i(pout), .port_oe_i(poe), .drive_i(drv),
    .pin_o(pin));
  // Verdict and end of run
  task complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Shift register source of random bytes
  function automatic logic [7:0] rnd();
    sd = {sd[6:0], sd[7] ^ sd[5] ^ sd[4] ^ sd[3]};
    return sd;
  endfunction : rnd
  // Bus write and read
  task wr(input logic [7:0] a_i, input logic [7:0] d_i);
    @(posedge clk) {addr, wd, wr_s} <= {a_i, d_i, 1'b1};
    @(posedge clk) wr_s <= 0;
  endtask : wr
  task rd(input logic [7:0] a_i, input logic [7:0] e_i);
    @(posedge clk) {addr, rd_s} <= {a_i, 1'b1};
    @(posedge clk) rd_s <= 0;
    #1 chk(rdata, e_i);
  endtask : rd
  // Clocks up to the next machine cycle pulse, bounded
  task gap;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (cyc !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      complete_run();
    end
  endtask : gap
  // One arithmetic step, waiting for done
  task alu(input alu_op_t o);
    @(posedge clk) begin
      op <= o;
      go <= 1'b1;
    end
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (done !== 1'b1 && k < 20);
    @(posedge clk) go <= 0;
    chk(k < 20, 1);
    if (k >= 20) complete_run();
  endtask : alu
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    rd(8'h03, 8'h07);
    chk(pout[1], 8'hff);
    gap(); gap(); chk(n, 4);
    wr(8'h09, 8'h01); gap(); gap(); chk(n, 64);
    wr(8'h09, 8'h02); gap(); gap(); chk(n, 1024);
    for (int i = 0; i < 2; i++) begin
      wr(8'h09, 8'h05); gap(); gap(); chk(n, 64);
      @(posedge clk) {irq, ser} <= i ? 2'b01 : 2'b10;
      @(posedge clk) {irq, ser} <= 2'b00;
      rd(8'h09, 8'h04);
      gap(); gap(); chk(n, 4);
    end
    $display("cycle test done");
    for (int i = 0; i < 16; i++) begin
      a = rnd();
      b = i == 15 ? 0 : rnd();
      ci = i / 8;
      wr(8'h00, 8'(a)); wr(8'h01, 8'(b)); wr(8'h02, 8'(ci * 128));
      alu(alu_op_t'(i[2:0]));
      // Reference step, flags kept unless the operation sets them
      ea = 8'(a);
      eb = 8'(b);
      cy = ci != 0;
      ac = 1'b0;
      ov = 1'b0;
      case (i % 8)
        0, 1: begin
          k = i % 8 == 1 ? ci : 0;
          s = a + b + k;
          ea = 8'(s);
          cy = s > 255;
          ac = (a % 16) + (b % 16) + k > 15;
          ov = ((a ^ s) & (b ^ s) & 128) != 0;
        end
        2: begin
          s = a - b - ci;
          ea = 8'(s);
          cy = s < 0;
          ac = (a % 16) - (b % 16) - ci < 0;
          ov = ((a ^ b) & (a ^ s) & 128) != 0;
        end
        3: ea = 8'(a & b);
        4: ea = 8'(a | b);
        5: ea = 8'(a ^ b);
        6: begin
          s = a * b;
          ea = 8'(s);
          eb = 8'(s / 256);
          cy = 1'b0;
          ov = s > 255;
        end
        7: begin
          cy = 1'b0;
          ov = b == 0;
          if (b != 0) begin
            ea = 8'(a / b);
            eb = 8'(a % b);
          end
        end
      endcase
      ep = {cy, ac, 3'b000, ov, 1'b0, ^ea};
      rd(8'h00, ea); rd(8'h01, eb);
      rd(8'h02, ep);
    end
    $display("alu test done");
    wr(8'h04, 8'h34); wr(8'h05, 8'h12); wr(8'h06, 8'hfe); wr(8'h07, 8'hab);
    wr(8'h08, 8'h01);
    @(posedge clk) dinc <= 1;
    @(posedge clk) dinc <= 0;
    repeat (2) @(posedge clk);
    #1 chk(xa, 16'habff);
    wr(8'h08, 8'h00);
    @(posedge clk) ext <= 1;
    repeat (3) @(posedge clk);
    #1 chk(xa, 16'h1234);
    chk({pout[2], pout[0]}, 16'h1234);
    @(posedge clk) {ext, pd, push} <= {1'b0, rnd(), 1'b1};
    @(posedge clk) push <= 0;
    rd(8'h03, 8'h08);
    wr(8'h40, 8'h08);
    repeat (2) @(posedge clk);
    rd(8'h41, pd);
    @(posedge clk) pop <= 1;
    @(posedge clk) pop <= 0;
    rd(8'h03, 8'h07);
    $display("pointer test done");
    @(posedge clk) drv <= rnd();
    rd(8'h10, 8'hff);
    wr(8'h11, 8'h0f); rd(8'h11, drv & 8'h0f);
    for (int j = 0; j < 6; j++) begin
      ea = rnd();
      wr(8'h20 + j, ea); rd(8'h20 + j, ea);
    end
    // Run timer 0 for three machine cycles across its wrap
    wr(8'h20, 8'hfe); wr(8'h21, 8'hff);
    gap(); wr(8'h28, 8'h01); gap(); gap(); gap(); wr(8'h28, 8'h70);
    rd(8'h20, 8'h01); rd(8'h21, 8'h00);
    rd(8'h28, 8'h10); wr(8'h28, 8'h00); rd(8'h28, 8'h00);
    rd(8'hff, 8'h00);
    $display("port timer test done");
    wr(8'h30, 8'h01);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (cpur !== 1'b1 && k < 200);
    chk(cpur, 1);
    if (k >= 200) complete_run();
    wr(8'h30, 8'h00);
    rd(8'h30, 8'h10);
    wr(8'h30, 8'h10); rd(8'h30, 8'h00);
    $display("watchdog test done");
    complete_run();
  end
endmodule : accumulator_core_register_set_tb_top
`default_nettype wire
